/* core/exp_pkg.sv */
package exp_pkg;
	localparam int NUM_PINS = 14;
	localparam logic [7:0] ADDR_IN_LO = 8'h00;
	localparam logic [7:0] ADDR_IN_HI = 8'h01;
	localparam logic [7:0] ADDR_OUT_LO = 8'h02;
	localparam logic [7:0] ADDR_OUT_HI = 8'h03;
	localparam logic [7:0] ADDR_CFG_LO = 8'h06;
	localparam logic [7:0] ADDR_CFG_HI = 8'h07;
	localparam logic [7:0] ADDR_DRV_0 = 8'h40;
	localparam logic [7:0] ADDR_DRV_1 = 8'h41;
	localparam logic [7:0] ADDR_DRV_2 = 8'h42;
	localparam logic [7:0] ADDR_DRV_3 = 8'h43;
	localparam logic [7:0] ADDR_PE_LO = 8'h46;
	localparam logic [7:0] ADDR_PE_HI = 8'h47;
	localparam logic [7:0] ADDR_PS_LO = 8'h48;
	localparam logic [7:0] ADDR_PS_HI = 8'h49;
	localparam logic [7:0] ADDR_FIRST = 8'h00;
	localparam logic [7:0] ADDR_LAST = 8'h49;
	// Slave address base; the low two bits come from the address strap. Value is arbitrary.
	localparam logic [4:0] SLAVE_BASE = 5'h08;
	localparam logic [13:0] RST_OUT = 14'h0000;
	localparam logic [13:0] RST_CFG = 14'h3FFF;
	localparam logic [27:0] RST_DRV = 28'hFFF_FFFF;
	localparam logic [13:0] RST_PE = 14'h0000;
	localparam logic [13:0] RST_PS = 14'h0000;
	localparam logic [4:0] BIT_RW = 5'h07;
	localparam logic [4:0] BIT_REGADDR = 5'h0F;
	localparam logic [4:0] BIT_DATA_END = 5'h17;
	localparam logic [4:0] BIT_DATA_START = 5'h10;
	localparam logic [1:0] DRV_HALF = 2'h2;
	localparam logic [3:0] FING_NONE = 4'h0;
	localparam logic [3:0] FING_ONE = 4'h1;
	localparam logic [3:0] FING_TWO = 4'h3;
	localparam logic [3:0] FING_ALL = 4'hF;
	typedef enum logic [2:0] {
		ST_HDR = 3'b001,
		ST_WR = 3'b010,
		ST_RD = 3'b100
	} exp_state_t;
endpackage

/* core/exp_pad.sv */
`timescale 1ns/1ps
module exp_pad (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Pin configuration
	input wire logic dir_in_in,
	input wire logic out_data_in,
	input wire logic [1:0] drive_code_in,
	input wire logic pull_en_in,
	input wire logic pull_sel_in,
	// Pad controls
	output logic pad_out,
	output logic pad_oe_n_out,
	output logic [3:0] finger_en_out,
	output logic pull_up_out,
	output logic pull_down_out
);
	logic [3:0] fing_nxt;
	logic [3:0] fing_r;
	logic oe_n_nxt;
	logic oe_n_r;
	logic dat_nxt;
	logic dat_r;
	logic pu_nxt;
	logic pu_r;
	logic pd_nxt;
	logic pd_r;

	// A code of 00 leaves no finger on, so the pin floats even when set as output.
	always_comb begin
		case (drive_code_in)
			2'h0: fing_nxt = exp_pkg::FING_NONE;
			2'h1: fing_nxt = exp_pkg::FING_ONE;
			exp_pkg::DRV_HALF: fing_nxt = exp_pkg::FING_TWO;
			default: fing_nxt = exp_pkg::FING_ALL;
		endcase
		oe_n_nxt = dir_in_in | (fing_nxt == exp_pkg::FING_NONE);
		dat_nxt = out_data_in;
		pu_nxt = pull_en_in & pull_sel_in;
		pd_nxt = pull_en_in & ~pull_sel_in;
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			fing_r <= exp_pkg::FING_NONE;
			oe_n_r <= 1'b1;
			dat_r <= 1'b0;
			pu_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			fing_r <= fing_nxt;
			oe_n_r <= oe_n_nxt;
			dat_r <= dat_nxt;
			pu_r <= pu_nxt;
			pd_r <= pd_nxt;
		end
	end

	assign finger_en_out = fing_r;
	assign pad_oe_n_out = oe_n_r;
	assign pad_out = dat_r;
	assign pull_up_out = pu_r;
	assign pull_down_out = pd_r;

	a_half_drive: assert property (@(posedge clk_in) disable iff (reset_in)
		(drive_code_in == exp_pkg::DRV_HALF) |=> (finger_en_out == exp_pkg::FING_TWO))
		else $error("half drive code did not give two fingers");
	a_pull_gate: assert property (@(posedge clk_in) disable iff (reset_in)
		!pull_en_in |=> (!pull_up_out && !pull_down_out))
		else $error("pull resistor on while disabled");
	a_pad_combine: assert property (@(posedge clk_in) disable iff (reset_in)
		(dir_in_in || drive_code_in == 2'h0) |=> pad_oe_n_out)
		else $error("pad driven while input or zero drive");
endmodule

/* core/exp_port.sv */
`timescale 1ns/1ps
module exp_port (
	// Clock and reset
	input wire logic clk_in,
	input wire logic reset_in,
	// Serial bus
	input wire logic cs_n_in,
	input wire logic sclk_in,
	input wire logic sdin_in,
	output logic sdout_out,
	output logic sdout_oe_n_out,
	// Address strap
	input wire logic [1:0] addr_sel_in,
	// Port pins
	input wire logic [13:0] pad_in,
	output logic [13:0] pad_out,
	output logic [13:0] pad_oe_n_out,
	output logic [55:0] finger_en_out,
	output logic [13:0] pull_up_out,
	output logic [13:0] pull_down_out
);
	exp_pkg::exp_state_t st_r, st_nxt;
	logic sclk_r;
	logic [4:0] cnt_r, cnt_nxt;
	logic [6:0] sh_r, sh_nxt;
	logic [7:0] addr_r, addr_nxt;
	logic [7:0] tx_r, tx_nxt;
	logic sdo_r, sdo_nxt;
	logic oe_n_r, oe_n_nxt;
	logic [13:0] in_r;
	logic [13:0] out_r, out_nxt;
	logic [13:0] cfg_r, cfg_nxt;
	logic [27:0] drv_r, drv_nxt;
	logic [13:0] pe_r, pe_nxt;
	logic [13:0] ps_r, ps_nxt;
	logic rise;
	logic fall;
	logic [7:0] byte_in;
	logic [7:0] step_addr;

	function automatic logic addr_valid(input logic [7:0] a);
		case (a)
			exp_pkg::ADDR_IN_LO, exp_pkg::ADDR_IN_HI, exp_pkg::ADDR_OUT_LO, exp_pkg::ADDR_OUT_HI,
			exp_pkg::ADDR_CFG_LO, exp_pkg::ADDR_CFG_HI, exp_pkg::ADDR_DRV_0, exp_pkg::ADDR_DRV_1,
			exp_pkg::ADDR_DRV_2, exp_pkg::ADDR_DRV_3, exp_pkg::ADDR_PE_LO, exp_pkg::ADDR_PE_HI,
			exp_pkg::ADDR_PS_LO, exp_pkg::ADDR_PS_HI: addr_valid = 1'b1;
			default: addr_valid = 1'b0;
		endcase
	endfunction

	function automatic logic [7:0] rd_mux(input logic [7:0] a);
		case (a)
			exp_pkg::ADDR_IN_LO: rd_mux = in_r[7:0];
			exp_pkg::ADDR_IN_HI: rd_mux = {2'h0, in_r[13:8]};
			exp_pkg::ADDR_OUT_LO: rd_mux = out_r[7:0];
			exp_pkg::ADDR_OUT_HI: rd_mux = {2'h0, out_r[13:8]};
			exp_pkg::ADDR_CFG_LO: rd_mux = cfg_r[7:0];
			exp_pkg::ADDR_CFG_HI: rd_mux = {2'h0, cfg_r[13:8]};
			exp_pkg::ADDR_DRV_0: rd_mux = drv_r[7:0];
			exp_pkg::ADDR_DRV_1: rd_mux = drv_r[15:8];
			exp_pkg::ADDR_DRV_2: rd_mux = drv_r[23:16];
			exp_pkg::ADDR_DRV_3: rd_mux = {4'h0, drv_r[27:24]};
			exp_pkg::ADDR_PE_LO: rd_mux = pe_r[7:0];
			exp_pkg::ADDR_PE_HI: rd_mux = {2'h0, pe_r[13:8]};
			exp_pkg::ADDR_PS_LO: rd_mux = ps_r[7:0];
			exp_pkg::ADDR_PS_HI: rd_mux = {2'h0, ps_r[13:8]};
			default: rd_mux = 8'h00;
		endcase
	endfunction

	// Inputs are synchronous to clk_in, so one stored copy of the clock pin is enough for edges.
	assign rise = !cs_n_in && !sclk_r && sclk_in;
	assign fall = !cs_n_in && sclk_r && !sclk_in;
	assign byte_in = {sh_r, sdin_in};
	assign step_addr = (addr_r == exp_pkg::ADDR_LAST) ? exp_pkg::ADDR_FIRST : 8'(addr_r + 8'h01);

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sh_nxt = sh_r;
		addr_nxt = addr_r;
		tx_nxt = tx_r;
		sdo_nxt = sdo_r;
		oe_n_nxt = oe_n_r;
		out_nxt = out_r;
		cfg_nxt = cfg_r;
		drv_nxt = drv_r;
		pe_nxt = pe_r;
		ps_nxt = ps_r;
		if (cs_n_in) begin
			// Chip select high ends any burst; a partial write never reached a commit point.
			st_nxt = exp_pkg::ST_HDR;
			cnt_nxt = 5'h00;
			oe_n_nxt = 1'b1;
		end else if (rise) begin
			sh_nxt = byte_in[6:0];
			cnt_nxt = (cnt_r == exp_pkg::BIT_DATA_END) ? exp_pkg::BIT_DATA_START : 5'(cnt_r + 5'h01);
			if (cnt_r == exp_pkg::BIT_RW) begin
				if (sh_r != {exp_pkg::SLAVE_BASE, addr_sel_in}) begin
					st_nxt = exp_pkg::ST_HDR;
				end else if (sdin_in) begin
					st_nxt = exp_pkg::ST_RD;
				end else begin
					st_nxt = exp_pkg::ST_WR;
				end
			end
			if (cnt_r == exp_pkg::BIT_RW && sh_r != {exp_pkg::SLAVE_BASE, addr_sel_in}) begin
				// A frame for another slave is ignored until chip select rises.
				cnt_nxt = 5'h18;
			end else if (cnt_r > exp_pkg::BIT_DATA_END) begin
				cnt_nxt = cnt_r;
			end
			if (cnt_r == exp_pkg::BIT_REGADDR) begin
				addr_nxt = byte_in;
				tx_nxt = rd_mux(byte_in);
			end
			if (cnt_r == exp_pkg::BIT_DATA_END && st_r != exp_pkg::ST_HDR) begin
				addr_nxt = step_addr;
				tx_nxt = rd_mux(step_addr);
			end
			if (cnt_r == exp_pkg::BIT_DATA_END && st_r == exp_pkg::ST_WR) begin
				case (addr_r)
					exp_pkg::ADDR_OUT_LO: out_nxt[7:0] = byte_in;
					exp_pkg::ADDR_OUT_HI: out_nxt[13:8] = byte_in[5:0];
					exp_pkg::ADDR_CFG_LO: cfg_nxt[7:0] = byte_in;
					exp_pkg::ADDR_CFG_HI: cfg_nxt[13:8] = byte_in[5:0];
					exp_pkg::ADDR_DRV_0: drv_nxt[7:0] = byte_in;
					exp_pkg::ADDR_DRV_1: drv_nxt[15:8] = byte_in;
					exp_pkg::ADDR_DRV_2: drv_nxt[23:16] = byte_in;
					exp_pkg::ADDR_DRV_3: drv_nxt[27:24] = byte_in[3:0];
					exp_pkg::ADDR_PE_LO: pe_nxt[7:0] = byte_in;
					exp_pkg::ADDR_PE_HI: pe_nxt[13:8] = byte_in[5:0];
					exp_pkg::ADDR_PS_LO: ps_nxt[7:0] = byte_in;
					exp_pkg::ADDR_PS_HI: ps_nxt[13:8] = byte_in[5:0];
					default: ;
				endcase
			end
		end else if (fall && st_r == exp_pkg::ST_RD && cnt_r >= exp_pkg::BIT_DATA_START) begin
			// Read data leaves on falling edges so it is settled at the master's rising edge.
			sdo_nxt = tx_r[7];
			tx_nxt = {tx_r[6:0], 1'b0};
			oe_n_nxt = !addr_valid(addr_r);
		end
	end

	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			st_r <= exp_pkg::ST_HDR;
			sclk_r <= 1'b0;
			cnt_r <= 5'h00;
			sh_r <= 7'h00;
			addr_r <= 8'h00;
			tx_r <= 8'h00;
			sdo_r <= 1'b0;
			oe_n_r <= 1'b1;
			in_r <= 14'h0000;
			out_r <= exp_pkg::RST_OUT;
			cfg_r <= exp_pkg::RST_CFG;
			drv_r <= exp_pkg::RST_DRV;
			pe_r <= exp_pkg::RST_PE;
			ps_r <= exp_pkg::RST_PS;
		end else begin
			st_r <= st_nxt;
			sclk_r <= sclk_in;
			cnt_r <= cnt_nxt;
			sh_r <= sh_nxt;
			addr_r <= addr_nxt;
			tx_r <= tx_nxt;
			sdo_r <= sdo_nxt;
			oe_n_r <= oe_n_nxt;
			in_r <= pad_in;
			out_r <= out_nxt;
			cfg_r <= cfg_nxt;
			drv_r <= drv_nxt;
			pe_r <= pe_nxt;
			ps_r <= ps_nxt;
		end
	end

	assign sdout_out = sdo_r;
	assign sdout_oe_n_out = oe_n_r;

	genvar gi;
	generate
		for (gi = 0; gi < exp_pkg::NUM_PINS; gi++) begin : g_pin
			exp_pad u_pad (
				.clk_in(clk_in),
				.reset_in(reset_in),
				.dir_in_in(cfg_r[gi]),
				.out_data_in(out_r[gi]),
				.drive_code_in(drv_r[2*gi +: 2]),
				.pull_en_in(pe_r[gi]),
				.pull_sel_in(ps_r[gi]),
				.pad_out(pad_out[gi]),
				.pad_oe_n_out(pad_oe_n_out[gi]),
				.finger_en_out(finger_en_out[4*gi +: 4]),
				.pull_up_out(pull_up_out[gi]),
				.pull_down_out(pull_down_out[gi])
			);
		end
	endgenerate

	sequence s_data_end;
		rise && cnt_r == exp_pkg::BIT_DATA_END && st_r != exp_pkg::ST_HDR;
	endsequence

	a_addr_step: assert property (@(posedge clk_in) disable iff (reset_in)
		s_data_end and (addr_r != exp_pkg::ADDR_LAST) |=> addr_r == 8'($past(addr_r) + 8'h01))
		else $error("burst address did not advance by one");
	a_addr_wrap: assert property (@(posedge clk_in) disable iff (reset_in)
		s_data_end and (addr_r == exp_pkg::ADDR_LAST) |=> addr_r == exp_pkg::ADDR_FIRST)
		else $error("burst address did not wrap");
	a_write_commit: assert property (@(posedge clk_in) disable iff (reset_in)
		s_data_end and (st_r == exp_pkg::ST_WR && addr_r == exp_pkg::ADDR_PE_LO)
		|=> pe_r[7:0] == $past(byte_in))
		else $error("pull enable write lost");
	a_short_write: assert property (@(posedge clk_in) disable iff (reset_in)
		!(rise && cnt_r == exp_pkg::BIT_DATA_END && st_r == exp_pkg::ST_WR)
		|=> $stable(ps_r) && $stable(pe_r) && $stable(drv_r))
		else $error("register changed without a complete byte");
	a_cs_ends: assert property (@(posedge clk_in) disable iff (reset_in)
		cs_n_in |=> cnt_r == 5'h00 && st_r == exp_pkg::ST_HDR && sdout_oe_n_out)
		else $error("transfer state kept after chip select rose");
	a_reset_init: assert property (@(posedge clk_in)
		reset_in |=> cfg_r == exp_pkg::RST_CFG && cnt_r == 5'h00 && st_r == exp_pkg::ST_HDR)
		else $error("reset did not initialise state");
	a_read_msb: assert property (@(posedge clk_in) disable iff (reset_in)
		(fall && st_r == exp_pkg::ST_RD && cnt_r >= exp_pkg::BIT_DATA_START)
		|=> sdout_out == $past(tx_r[7]))
		else $error("read bit not driven from shift register");
	a_pull_dir: assert property (@(posedge clk_in) disable iff (reset_in)
		##1 (pull_up_out[0] == ($past(pe_r[0]) && $past(ps_r[0]))))
		else $error("pull direction does not follow select");
endmodule

/* testbench/exp_spi_master.sv */
`timescale 1ns/1ps
module exp_spi_master (
	// Clock
	input wire logic clk_in,
	// Serial bus
	output logic cs_n_out = 1'b1,
	output logic sclk_out = 1'b0,
	output logic sdin_out = 1'b0,
	input wire logic sdout_in,
	input wire logic sdout_oe_n_in,
	// Read results, bit 8 set when every bit was driven
	output logic rd_valid_out = 1'b0,
	output logic [8:0] rd_byte_out = 9'h000
);
	// Each serial level holds four clocks so the slave's edge detector never misses one.
	task automatic frame(input logic [6:0] sa, input logic rd, input logic [7:0] ra, input int nbits,
		input logic [31:0] wd);
		logic [15:0] hdr;
		logic [8:0] rx;
		hdr = {sa, rd, ra};
		rx = 9'h100;
		@(posedge clk_in);
		cs_n_out <= 1'b0;
		repeat (2) @(posedge clk_in);
		for (int k = 0; k < 16 + nbits; k++) begin
			sdin_out <= (k < 16) ? hdr[15 - k] : wd[47 - k];
			sclk_out <= 1'b0;
			repeat (4) @(posedge clk_in);
			sclk_out <= 1'b1;
			if (rd && k >= 16) begin
				// A released data line reads back as the inverse of its last level.
				rx = {rx[8] & ~sdout_oe_n_in, rx[6:0], sdout_oe_n_in ? ~sdout_in : sdout_in};
				if (k % 8 == 7) begin
					rd_byte_out <= rx;
					rd_valid_out <= 1'b1;
					rx = 9'h100;
				end
			end
			@(posedge clk_in);
			rd_valid_out <= 1'b0;
			repeat (3) @(posedge clk_in);
		end
		sclk_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		cs_n_out <= 1'b1;
		// A released data line must not keep showing the last bit.
		sdin_out <= ~sdin_out;
		repeat (4) @(posedge clk_in);
	endtask
endmodule

/* testbench/tb.sv */
`timescale 1ns/1ps
module tb;
	logic clk_in = 1'b0;
	logic reset_in = 1'b1;
	logic [1:0] addr_sel_in = 2'h0;
	logic [13:0] pad_in = 14'h0000;
	logic cs_n, sclk, sdin, sdout, sdout_oe_n, rd_valid;
	logic snap = 1'b0;
	logic [8:0] rd_byte;
	logic [8:0] e_rd;
	logic [13:0] pad_out, pad_oe_n, pull_up, pull_down, sh_out, sh_cfg, sh_pe, sh_ps;
	logic [55:0] finger_en;
	logic [27:0] sh_drv;
	logic [6:0] sa;
	logic [31:0] r;
	logic [8:0] exp_rd[$];
	logic [111:0] exp_pad[$];
	int fail_count = 0;
	int checked = 0;
	always #4 clk_in = ~clk_in;
	exp_port uut (.clk_in(clk_in), .reset_in(reset_in), .cs_n_in(cs_n), .sclk_in(sclk), .sdin_in(sdin),
		.sdout_out(sdout), .sdout_oe_n_out(sdout_oe_n), .addr_sel_in(addr_sel_in), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe_n_out(pad_oe_n), .finger_en_out(finger_en), .pull_up_out(pull_up),
		.pull_down_out(pull_down));
	exp_spi_master m (.clk_in(clk_in), .cs_n_out(cs_n), .sclk_out(sclk), .sdin_out(sdin), .sdout_in(sdout),
		.sdout_oe_n_in(sdout_oe_n), .rd_valid_out(rd_valid), .rd_byte_out(rd_byte));
	task automatic give_verdict();
		// Expected results that never showed up count against the run.
		if (exp_rd.size() != 0 || exp_pad.size() != 0) fail_count++;
		if (fail_count == 0 && checked > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	task automatic cmp(input logic [111:0] e, input logic [111:0] o);
		checked++;
		if (o !== e) begin
			fail_count++;
			$display("FAIL at %0t: expected %h, got %h", $time, e, o);
		end
	endtask
	always @(posedge clk_in) begin
		if (rd_valid === 1'b1) begin
			e_rd = exp_rd.pop_front();
			// A byte that was never driven carries only its flag, its data bits mean nothing.
			cmp({103'h0, e_rd}, {103'h0, rd_byte[8], e_rd[8] ? rd_byte[7:0] : e_rd[7:0]});
		end
		if (snap === 1'b1) cmp(exp_pad.pop_front(), {pull_up, pull_down, pad_oe_n, pad_out, finger_en});
	end
	function automatic logic [111:0] pads();
		logic [55:0] f;
		logic [13:0] oe;
		logic [1:0] c;
		for (int i = 0; i < 14; i++) begin
			c = sh_drv[2 * i +: 2];
			f[4 * i +: 4] = (c == 2'h0) ? exp_pkg::FING_NONE : (c == 2'h1) ? exp_pkg::FING_ONE :
				(c == exp_pkg::DRV_HALF) ? exp_pkg::FING_TWO : exp_pkg::FING_ALL;
			oe[i] = sh_cfg[i] | (c == 2'h0);
		end
		return {sh_pe & sh_ps, sh_pe & ~sh_ps, oe, sh_out, f};
	endfunction
	task automatic snapshot();
		repeat (4) @(posedge clk_in);
		exp_pad.push_back(pads());
		snap <= 1'b1;
		@(posedge clk_in);
		snap <= 1'b0;
	endtask
	task automatic do_reset();
		reset_in <= 1'b1;
		repeat (20) @(posedge clk_in);
		reset_in <= 1'b0;
		sh_out = exp_pkg::RST_OUT;
		sh_cfg = exp_pkg::RST_CFG;
		sh_drv = exp_pkg::RST_DRV;
		sh_pe = exp_pkg::RST_PE;
		sh_ps = exp_pkg::RST_PS;
	endtask
	task automatic rd(input logic [7:0] ra, input int n, input logic [31:0] e);
		for (int i = 0; i < n; i++) exp_rd.push_back({1'b1, e[31 - 8 * i -: 8]});
		m.frame(sa, 1'b1, ra, 8 * n, $urandom);
	endtask
	initial begin
		r = $urandom(45275);
		r = $urandom;
		addr_sel_in <= r[1:0];
		pad_in <= r[15:2];
		sa = {exp_pkg::SLAVE_BASE, r[1:0]};
		do_reset();
		snapshot();
		rd(exp_pkg::ADDR_PE_LO, 4, 32'h0000_0000);
		// Upper bits of the high bytes have no pins behind them, so they stay clear.
		r = $urandom & 32'hFF3F_FF3F;
		m.frame(sa, 1'b0, exp_pkg::ADDR_PE_LO, 32, r);
		sh_pe = {r[21:16], r[31:24]};
		sh_ps = {r[5:0], r[15:8]};
		snapshot();
		rd(exp_pkg::ADDR_PE_LO, 4, r);
		rd(exp_pkg::ADDR_PS_HI, 2, {r[7:0], pad_in[7:0], 16'h0000});
		exp_rd.push_back(9'h000);
		m.frame(sa, 1'b1, 8'h04, 8, $urandom);
		m.frame(sa, 1'b0, exp_pkg::ADDR_PE_LO, 7, 32'hFFFF_FFFF);
		m.frame(sa ^ 7'h01, 1'b0, exp_pkg::ADDR_PE_LO, 8, 32'hFFFF_FFFF);
		snapshot();
		r = $urandom & 32'hFF3F_FF3F;
		m.frame(sa, 1'b0, exp_pkg::ADDR_OUT_LO, 16, {r[31:16], 16'h0000});
		m.frame(sa, 1'b0, exp_pkg::ADDR_CFG_LO, 16, {r[15:0], 16'h0000});
		m.frame(sa, 1'b0, exp_pkg::ADDR_DRV_0, 32, 32'hE4E4_E404);
		sh_out = {r[21:16], r[31:24]};
		sh_cfg = {r[5:0], r[15:8]};
		sh_drv = 28'h4E4_E4E4;
		snapshot();
		do_reset();
		snapshot();
		repeat (2) @(posedge clk_in);
		give_verdict();
	end
	initial begin
		repeat (40000) @(posedge clk_in);
		fail_count++;
		give_verdict();
	end
endmodule
